// ===== common/aicfg_pkg.sv
// Purpose: constants shared by the analog input config/status word logic
// Assumes: 25 MHz core clock, word index times four is the APB byte address
// Notes: timing counts are derived from the printed times
// Function
// [R1] index 13 writes config, reads status
// [R2] status snapshot refreshed once per sample period
// [R3] bit 0 configures and reports configured
// [R4] unconfigured data reads give attention status
// [R5] write bit 1 forces error, lights LED
// [R6] bit 1 internal or forced; LED follows
// [R7] error bit set gives attention on data
// [R8] group 1 unused status bits read zero
// [R9] warm-up 8.16 s sets bit 4, error
// [R10] bit 7 checksum fail, LED, point fault
// [R11] bit 8 selects 60 or 50 per second
// [R12] bit 11 starts self-cal at two per second
// [R13] bit 13 memory fault, LED, point fault
// [R14] bit 15 ors point flags and 1,4,7,13
// [R15] point-quality word only for point faults
// [R16] group 2 14-bit range select readback
// [R17] range decode 1V, 250mV, 100mV, invalid
// [R18] controller writes zero to diagnostic bits
// [R19] group 1 diagnostic status bits 10-12, 14
// [R20] group 2 diagnostic status bits 2,3,11,12
// [R21] group 2 start, lock, clear calibration
// [R22] group and resolution are build parameters
package aicfg_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int WARMUP_MS = 8160;
   localparam int WARMUP_CYC = WARMUP_MS * (CLK_HZ / 1000);
   localparam int RATE_60 = 60;
   localparam int RATE_50 = 50;
   localparam int RATE_CAL = 2;
   localparam int PERIOD_60 = (CLK_HZ + RATE_60 - 1) / RATE_60;
   localparam int PERIOD_50 = (CLK_HZ + RATE_50 - 1) / RATE_50;
   localparam int PERIOD_CAL = (CLK_HZ + RATE_CAL - 1) / RATE_CAL;
   localparam int CAL_SAMPLES_DEF = 4;
   localparam int WORD_W = 16;
   localparam int NUM_DATA = 12;
   localparam int NUM_POINTS = 8;
   localparam int DIAG_ADDR_W = 5;
   localparam int IDX_W = 6;
   localparam logic [IDX_W-1:0] IDX_DATA_LAST = 6'h0B;
   localparam logic [IDX_W-1:0] IDX_POINTQ = 6'h0C;
   localparam logic [IDX_W-1:0] IDX_CFG = 6'h0D;
   localparam int B_CONFIG = 0;
   localparam int B_FORCE = 1;
   localparam int B_ADDR_LO = 2;
   localparam int B_WARM = 4;
   localparam int B_CHKSUM = 7;
   localparam int B_DIAG_ENTRY = 7;
   localparam int B_RATE = 8;
   localparam int B_RANGE_LO = 9;
   localparam int B_SELFCAL = 11;
   localparam int B_MEMERR = 13;
   localparam int B_FAULT = 15;
   localparam int G1_SC_START = 10;
   localparam int G1_SC_BUSY = 10;
   localparam int G1_SC_DONE = 11;
   localparam int G1_SC_FAIL = 12;
   localparam int G1_DIAG = 14;
   localparam int G2_SC_BUSY = 2;
   localparam int G2_DIAG = 3;
   localparam int G2_SC_DONE = 11;
   localparam int G2_SC_FAIL = 12;
   localparam int G2_SC_START = 12;
   localparam int G2_LOCK = 13;
   localparam int G2_CLEAR = 14;
   localparam logic [WORD_W-1:0] G1_QUIET_MASK = 16'h566C;
   typedef enum logic [1:0] {RANGE_1V, RANGE_250MV, RANGE_100MV, RANGE_BAD} range_e;
   typedef enum logic {CAL_IDLE, CAL_RUN} cal_e;
endpackage

// ===== common/sample_if.sv
// Purpose: sampling timing signals between the core and its timers
// Assumes: all signals on the core clock
// Notes: tick is a one-cycle pulse per sampling period
interface sample_if;
   logic tick;
   logic slow;
   logic rate50;
   logic warming;
   modport ticker (input slow, input rate50, output tick);
   modport timer (output warming);
endinterface

// ===== hw/sample_tick.sv
// Purpose: sampling period pulse generator
// Assumes: slow and rate50 from the core clock domain
// Notes: the period changes at once; the running count is compared with the new limit
module sample_tick
   import aicfg_pkg::*;
#(
   parameter int P60 = PERIOD_60,
   parameter int P50 = PERIOD_50,
   parameter int PCAL = PERIOD_CAL
)(
   input wire logic clk,
   input wire logic rst_n,
   sample_if.ticker bus
);
   localparam int MAXP = (PCAL > P60) ? ((PCAL > P50) ? PCAL : P50) : ((P60 > P50) ? P60 : P50);
   localparam int CW = $clog2(MAXP + 1);
   logic [CW-1:0] count;
   logic [CW-1:0] limit;
   always_comb begin
      if (bus.slow) begin
         limit = CW'(PCAL - 1); // R12
      end else if (bus.rate50) begin
         limit = CW'(P50 - 1); // R11
      end else begin
         limit = CW'(P60 - 1);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (count >= limit) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end
   assign bus.tick = (count >= limit);
endmodule

// ===== hw/warmup_timer.sv
// Purpose: power-up warm-up interval
// Assumes: reset marks power-up
// Notes: warming is held from reset for the full interval
module warmup_timer
   import aicfg_pkg::*;
#(
   parameter int CYCLES = WARMUP_CYC
)(
   input wire logic clk,
   input wire logic rst_n,
   sample_if.timer bus
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] count;
   logic warming;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         warming <= 1'b1;
      end else if (warming) begin
         count <= count + 1'b1;
         if (count == CW'(CYCLES - 1)) begin
            warming <= 1'b0; // R9
         end
      end
   end
   assign bus.warming = warming;
endmodule

// ===== hw/aicfg_top.sv
// Purpose: configuration and module status word with APB access
// Assumes: conversion engine inputs run on CORE_CLK
// Notes: zero wait APB; read data captured in the setup cycle
//
// Implementation choice: the APB slave port.
module aicfg_top
   import aicfg_pkg::*;
#(
   parameter int GROUP = 1,
   parameter int RES_BITS = 13,
   parameter int WARMUP_CYCLES = WARMUP_CYC,
   parameter int PERIOD_60HZ = PERIOD_60,
   parameter int PERIOD_50HZ = PERIOD_50,
   parameter int PERIOD_SELFCAL = PERIOD_CAL,
   parameter int CAL_SAMPLES = CAL_SAMPLES_DEF
)(
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [NUM_DATA*WORD_W-1:0] CHANNEL_WORDS,
   input wire logic [NUM_POINTS-1:0] POINT_BAD,
   input wire logic CHECKSUM_FAIL,
   input wire logic MEMORY_FAULT,
   input wire logic DIAG_ACTIVE,
   input wire logic SYSCAL_BUSY,
   input wire logic SYSCAL_DONE,
   input wire logic SYSCAL_FAIL,
   output logic ERROR_LED,
   output logic RATE_50HZ,
   output logic [1:0] RANGE_SEL,
   output logic RANGE_INVALID,
   output logic SELF_CAL_ACTIVE,
   output logic SAMPLE_TICK,
   output logic [DIAG_ADDR_W-1:0] DIAG_ADDR,
   output logic DIAG_ENTRY,
   output logic SYSCAL_START,
   output logic CAL_LOCK_GAIN,
   output logic CAL_CLEAR
);
   localparam int SC_START = (GROUP == 1) ? G1_SC_START : G2_SC_START;
   localparam bit HAS_RANGE = (GROUP == 2) && (RES_BITS == 14);
   localparam int CCW = $clog2(CAL_SAMPLES + 1);

   if (!(GROUP == 1 || GROUP == 2) || !(RES_BITS == 13 || RES_BITS == 14)
       || CAL_SAMPLES < 1) begin : g_bad_params
      $error("unsupported group, resolution or calibration length"); // R22
   end

   sample_if sif();

   sample_tick #(
      .P60(PERIOD_60HZ),
      .P50(PERIOD_50HZ),
      .PCAL(PERIOD_SELFCAL)
   ) u_tick (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .bus(sif)
   );

   warmup_timer #(
      .CYCLES(WARMUP_CYCLES)
   ) u_warm (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .bus(sif)
   );

   logic [IDX_W-1:0] idx;
   logic aligned;
   logic wr_cfg;
   logic setup;
   logic configured;
   logic force_err;
   logic rate50;
   logic [1:0] range_sel;
   logic [WORD_W-1:0] status;
   logic [WORD_W-1:0] next_status;
   logic [WORD_W-1:0] pq_word;
   logic [WORD_W-1:0] next_pq;
   logic primed;
   logic load;
   logic attention;
   logic [31:0] next_rdata;
   logic next_err;
   logic internal_err;
   logic module_fault;
   cal_e cal_state;
   logic [CCW-1:0] cal_count;

   // address decode
   assign idx = PADDR[7:2];
   assign aligned = (PADDR[1:0] == 2'h0);
   assign setup = PSEL && !PENABLE;
   assign wr_cfg = PSEL && PENABLE && PWRITE && aligned && (idx == IDX_CFG); // R1
   assign PREADY = 1'b1;

   // status refresh at each sampling tick, and once right after reset
   assign load = sif.tick || !primed; // R2
   assign SAMPLE_TICK = sif.tick;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         primed <= 1'b0;
      end else begin
         primed <= 1'b1;
      end
   end

   // configuration bits held from the last write
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         configured <= 1'b0;
         force_err <= 1'b0;
         rate50 <= 1'b0;
         range_sel <= 2'h0;
         DIAG_ADDR <= '0;
      end else if (wr_cfg) begin
         configured <= PWDATA[B_CONFIG]; // R3
         force_err <= PWDATA[B_FORCE]; // R5
         rate50 <= PWDATA[B_RATE]; // R11
         DIAG_ADDR <= PWDATA[B_ADDR_LO +: DIAG_ADDR_W];
         if (HAS_RANGE) begin
            range_sel <= PWDATA[B_RANGE_LO +: 2]; // R16
         end
      end
   end

   // one-cycle command pulses from a configuration write
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         DIAG_ENTRY <= 1'b0;
         SYSCAL_START <= 1'b0;
         CAL_LOCK_GAIN <= 1'b0;
         CAL_CLEAR <= 1'b0;
      end else begin
         DIAG_ENTRY <= wr_cfg && PWDATA[B_DIAG_ENTRY];
         SYSCAL_START <= wr_cfg && PWDATA[SC_START]; // R21
         CAL_LOCK_GAIN <= (GROUP == 2) && wr_cfg && PWDATA[SC_START] && PWDATA[G2_LOCK]; // R21
         CAL_CLEAR <= (GROUP == 2) && wr_cfg && PWDATA[SC_START] && PWDATA[G2_CLEAR]; // R21
      end
   end

   assign RATE_50HZ = rate50;
   assign RANGE_SEL = range_sel;
   assign RANGE_INVALID = (range_e'(range_sel) == RANGE_BAD); // R17
   assign sif.rate50 = rate50;

   // self-calibration: runs for a number of slow sampling periods
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cal_state <= CAL_IDLE;
         cal_count <= '0;
      end else begin
         case (cal_state)
            CAL_IDLE: begin
               cal_count <= '0;
               if (wr_cfg && PWDATA[B_SELFCAL]) begin
                  cal_state <= CAL_RUN; // R12
               end
            end
            CAL_RUN: begin
               if (sif.tick) begin
                  if (cal_count == CCW'(CAL_SAMPLES - 1)) begin
                     cal_state <= CAL_IDLE;
                  end else begin
                     cal_count <= cal_count + 1'b1;
                  end
               end
            end
            default: begin
               cal_state <= CAL_IDLE;
            end
         endcase
      end
   end

   assign sif.slow = (cal_state == CAL_RUN); // R12
   assign SELF_CAL_ACTIVE = (cal_state == CAL_RUN);

   // status word content
   assign internal_err = sif.warming || CHECKSUM_FAIL || MEMORY_FAULT; // R9
   always_comb begin
      next_status = '0; // R8
      next_status[B_CONFIG] = configured; // R3
      next_status[B_FORCE] = force_err || internal_err; // R6
      next_status[B_WARM] = sif.warming; // R9
      next_status[B_CHKSUM] = CHECKSUM_FAIL; // R10
      next_status[B_RATE] = rate50; // R11
      next_status[B_MEMERR] = MEMORY_FAULT; // R13
      if (GROUP == 1) begin
         next_status[G1_SC_BUSY] = DIAG_ACTIVE && SYSCAL_BUSY; // R19
         next_status[G1_SC_DONE] = DIAG_ACTIVE && SYSCAL_DONE; // R19
         next_status[G1_SC_FAIL] = DIAG_ACTIVE && SYSCAL_FAIL; // R19
         next_status[G1_DIAG] = DIAG_ACTIVE; // R19
      end else begin
         next_status[G2_SC_BUSY] = DIAG_ACTIVE && SYSCAL_BUSY; // R20
         next_status[G2_DIAG] = DIAG_ACTIVE; // R20
         next_status[G2_SC_DONE] = DIAG_ACTIVE && SYSCAL_DONE; // R20
         next_status[G2_SC_FAIL] = DIAG_ACTIVE && SYSCAL_FAIL; // R20
         if (HAS_RANGE) begin
            next_status[B_RANGE_LO +: 2] = range_sel; // R16
         end
      end
      next_status[B_FAULT] = (|POINT_BAD) || next_status[B_FORCE]
         || next_status[B_WARM] || next_status[B_CHKSUM]
         || next_status[B_MEMERR]; // R14
   end

   // point-quality word only carries data for point faults
   always_comb begin
      next_pq = '0;
      if (!next_status[B_FORCE] && !next_status[B_WARM]
          && !next_status[B_CHKSUM] && !next_status[B_MEMERR]) begin
         next_pq[NUM_POINTS-1:0] = POINT_BAD; // R15
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         status <= '0;
         pq_word <= '0;
      end else if (load) begin
         status <= next_status; // R2
         pq_word <= next_pq;
      end
   end

   assign ERROR_LED = status[B_FORCE]; // R6
   assign module_fault = status[B_FORCE];

   // attention on channel data while unconfigured or in error
   assign attention = !status[B_CONFIG] || module_fault; // R4

   // read data and error answer, captured in the setup cycle
   always_comb begin
      next_rdata = '0;
      next_err = 1'b0;
      if (!aligned || idx > IDX_CFG) begin
         next_err = 1'b1;
      end else if (idx == IDX_CFG) begin
         next_rdata[WORD_W-1:0] = status; // R1
      end else if (idx == IDX_POINTQ) begin
         next_rdata[WORD_W-1:0] = pq_word; // R15
      end else if (!PWRITE && attention) begin
         next_err = 1'b1; // R7
      end else begin
         next_rdata[WORD_W-1:0] = CHANNEL_WORDS[WORD_W*int'(idx) +: WORD_W];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
         PSLVERR <= next_err;
      end
   end

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);

   sequence s_rd_setup;
      PSEL && !PENABLE && !PWRITE;
   endsequence

   sequence s_data_read;
      s_rd_setup ##0 (aligned && idx <= IDX_DATA_LAST);
   endsequence

   sequence s_cfg_write;
      PSEL && PENABLE && PWRITE && aligned && idx == IDX_CFG;
   endsequence

   property p_cfg_read;
      s_rd_setup ##0 (aligned && idx == IDX_CFG) |=> PRDATA[WORD_W-1:0] == $past(status);
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("status read mismatch"); // R1

   property p_snapshot;
      !load |=> $stable(status);
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("status changed between ticks"); // R2

   property p_configured;
      load && configured |=> status[B_CONFIG];
   endproperty
   a_configured: assert property (p_configured) else $error("configured bit not shown"); // R3

   property p_unconf_attention;
      s_data_read ##0 !status[B_CONFIG] |=> PSLVERR;
   endproperty
   a_unconf_attention: assert property (p_unconf_attention) else $error("no attention"); // R4

   property p_force;
      load && force_err |=> ERROR_LED;
   endproperty
   a_force: assert property (p_force) else $error("forced error not lit"); // R5

   property p_force_bit;
      s_cfg_write ##0 PWDATA[B_FORCE] |=> force_err;
   endproperty
   a_force_bit: assert property (p_force_bit) else $error("force error not taken"); // R5

   property p_internal_led;
      load && internal_err |=> ERROR_LED && status[B_FORCE];
   endproperty
   a_internal_led: assert property (p_internal_led) else $error("internal error not lit"); // R6

   property p_err_attention;
      s_data_read ##0 status[B_FORCE] |=> PSLVERR && PRDATA == 32'h00000000;
   endproperty
   a_err_attention: assert property (p_err_attention) else $error("no attention"); // R7

   property p_g1_quiet;
      (GROUP == 1) && !DIAG_ACTIVE && load |=> (status & G1_QUIET_MASK) == '0;
   endproperty
   a_g1_quiet: assert property (p_g1_quiet) else $error("unused bits not zero"); // R8

   property p_warm;
      load && sif.warming |=> status[B_WARM] && status[B_FORCE] && status[B_FAULT];
   endproperty
   a_warm: assert property (p_warm) else $error("warm-up not reported"); // R9

   property p_checksum;
      status[B_CHKSUM] |-> status[B_FAULT] && ERROR_LED;
   endproperty
   a_checksum: assert property (p_checksum) else $error("checksum fault not shown"); // R10

   property p_rate;
      s_cfg_write |=> RATE_50HZ == $past(PWDATA[B_RATE]);
   endproperty
   a_rate: assert property (p_rate) else $error("rate select not taken"); // R11

   property p_selfcal;
      s_cfg_write ##0 PWDATA[B_SELFCAL] |=> SELF_CAL_ACTIVE;
   endproperty
   a_selfcal: assert property (p_selfcal) else $error("self-calibration not started"); // R12

   property p_memerr;
      status[B_MEMERR] |-> status[B_FAULT] && ERROR_LED;
   endproperty
   a_memerr: assert property (p_memerr) else $error("memory fault not shown"); // R13

   property p_point_fault;
      load && (|POINT_BAD) |=> status[B_FAULT];
   endproperty
   a_point_fault: assert property (p_point_fault) else $error("point fault not shown"); // R14

   property p_pq_only;
      pq_word != '0 |-> !status[B_FORCE] && !status[B_CHKSUM] && !status[B_MEMERR];
   endproperty
   a_pq_only: assert property (p_pq_only) else $error("quality word during module fault"); // R15

   property p_range;
      s_cfg_write ##0 HAS_RANGE |=> RANGE_SEL == $past(PWDATA[B_RANGE_LO +: 2]);
   endproperty
   a_range: assert property (p_range) else $error("range not taken"); // R16

   property p_no_range;
      !HAS_RANGE |-> RANGE_SEL == 2'h0 && (GROUP == 1 || status[B_RANGE_LO +: 2] == 2'h0);
   endproperty
   a_no_range: assert property (p_no_range) else $error("range set without support"); // R17

   property p_syscal_start;
      s_cfg_write ##0 PWDATA[SC_START] |=> SYSCAL_START ##1 !SYSCAL_START;
   endproperty
   a_syscal_start: assert property (p_syscal_start) else $error("start pulse wrong"); // R21

endmodule

// ===== bench/apb_ctl.sv
// Purpose: controller model issuing APB word reads and writes
// Assumes: each transfer is started right after a rising edge, or right after a falling edge when it follows gap
// Notes: diagnostic write field is kept zero outside diagnostics
module apb_ctl (
   input wire logic clk,
   input wire logic tick,
   input wire logic diag,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      logic [31:0] w;
      w = d;
      if (diag !== 1'b1) begin
         w[7:2] = 6'h00;
      end
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= w;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // status follows a write at the next sampling tick, up to one sampling period later
   task automatic wait_tick();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (tick !== 1'b1 && n < 2000);
      @(posedge clk);
   endtask
endmodule

// ===== bench/tb_top.sv
// Purpose: self-checking bench of the config and status word
// Assumes: group 1, 13-bit, shortened counts
// Notes: status checked after two sampling ticks
module tb_top
   import aicfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [NUM_DATA*WORD_W-1:0] chan;
   logic [NUM_POINTS-1:0] pbad = 8'h00;
   logic cks = 1'b0, mem = 1'b0, diag = 1'b0, busy = 1'b0, done = 1'b0, fail = 1'b0;
   logic led, r50, rinv, scal, tick, dent, sstart, lock, clr;
   logic [1:0] rsel;
   logic [DIAG_ADDR_W-1:0] daddr;
   int failures = 0, tests_run = 0, n_dent = 0, n_start = 0, n_cal = 0;
   always #20 clk = ~clk;
   aicfg_top #(.WARMUP_CYCLES(50), .PERIOD_60HZ(20),
      .PERIOD_50HZ(24), .PERIOD_SELFCAL(40), .CAL_SAMPLES(2)) DUT (
      .CORE_CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .CHANNEL_WORDS(chan), .POINT_BAD(pbad),
      .CHECKSUM_FAIL(cks), .MEMORY_FAULT(mem), .DIAG_ACTIVE(diag),
      .SYSCAL_BUSY(busy), .SYSCAL_DONE(done), .SYSCAL_FAIL(fail), .ERROR_LED(led),
      .RATE_50HZ(r50), .RANGE_SEL(rsel), .RANGE_INVALID(rinv),
      .SELF_CAL_ACTIVE(scal), .SAMPLE_TICK(tick), .DIAG_ADDR(daddr),
      .DIAG_ENTRY(dent), .SYSCAL_START(sstart), .CAL_LOCK_GAIN(lock), .CAL_CLEAR(clr));
   apb_ctl CTL (.clk(clk), .tick(tick), .diag(diag), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   always @(negedge clk) begin
      if (dent === 1'b1) n_dent++;
      if (sstart === 1'b1) n_start++;
      if (lock === 1'b1 || clr === 1'b1) n_cal++;
   end
   task automatic test_done();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         failures++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      CTL.xfer(1'b0, a, 32'h00000000, q, e);
      chk(q === {16'h0000, x} && e === xe, "read data or error flag");
   endtask
   task automatic wr(input logic [15:0] d);
      logic [31:0] q;
      logic e;
      CTL.xfer(1'b1, 8'h34, {16'h0000, d}, q, e);
   endtask
   task automatic tk(input int n);
      repeat (n) CTL.wait_tick();
   endtask
   task automatic gap(input int p);
      int n;
      CTL.wait_tick();
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (tick !== 1'b1 && n < 100);
      chk(n == p, "tick spacing");
   endtask
   task automatic t_warm();
      repeat (3) @(posedge clk);
      rd(8'h34, 16'h8012, 1'b0);
      chk(led === 1'b1, "led in warm-up");
      rd(8'h2C, 16'h0000, 1'b1);
      repeat (50) @(posedge clk);
      tk(2);
      rd(8'h34, 16'h0000, 1'b0);
      chk(led === 1'b0, "led after warm-up");
   endtask
   task automatic t_cfg();
      tk(1);
      wr(16'h0001);
      rd(8'h34, 16'h0000, 1'b0);
      tk(2);
      rd(8'h34, 16'h0001, 1'b0);
      rd(8'h14, 16'hA005, 1'b0);
      rd(8'h2C, 16'hA00B, 1'b0);
      rd(8'h38, 16'h0000, 1'b1);
      rd(8'h35, 16'h0000, 1'b1);
   endtask
   task automatic t_force();
      wr(16'h0003);
      tk(2);
      rd(8'h34, 16'h8003, 1'b0);
      chk(led === 1'b1, "forced led");
      rd(8'h00, 16'h0000, 1'b1);
      wr(16'h0001);
      tk(2);
      chk(led === 1'b0, "led cleared");
   endtask
   task automatic t_rate();
      gap(20);
      wr(16'h0301);
      chk(r50 === 1'b1, "rate output");
      chk(rsel === 2'b00 && rinv === 1'b0, "no range in group 1");
      tk(2);
      rd(8'h34, 16'h0101, 1'b0);
      gap(24);
      wr(16'h0001);
      tk(2);
   endtask
   task automatic t_fault();
      cks <= 1'b1;
      pbad <= 8'h5A;
      tk(2);
      rd(8'h34, 16'h8083, 1'b0);
      chk(led === 1'b1, "checksum led");
      rd(8'h30, 16'h0000, 1'b0);
      cks <= 1'b0;
      mem <= 1'b1;
      tk(2);
      rd(8'h34, 16'hA003, 1'b0);
      chk(led === 1'b1, "memory fault led");
      mem <= 1'b0;
      tk(2);
      rd(8'h34, 16'h8001, 1'b0);
      rd(8'h30, 16'h005A, 1'b0);
      rd(8'h00, 16'hA000, 1'b0);
      pbad <= 8'h00;
      tk(2);
      rd(8'h34, 16'h0001, 1'b0);
   endtask
   task automatic t_scal();
      int n;
      wr(16'h0801);
      chk(scal === 1'b1, "self-cal started");
      tk(1);
      rd(8'h34, 16'h0001, 1'b0);
      n = 0;
      while (scal === 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk(scal === 1'b0, "self-cal ended");
   endtask
   task automatic t_diag();
      diag <= 1'b1;
      busy <= 1'b1;
      done <= 1'b1;
      fail <= 1'b1;
      tk(2);
      rd(8'h34, 16'h5C01, 1'b0);
      wr(16'h00FD);
      chk(daddr === 5'h1F && n_dent == 1, "diag address and entry");
      wr(16'h0401);
      chk(n_start == 1, "system calibration start");
      chk(n_cal == 0, "no gain lock or clear in group 1");
      diag <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      tk(2);
      rd(8'h34, 16'h0001, 1'b0);
      wr(16'h00FD);
      chk(daddr === 5'h00 && n_dent == 1, "field zero outside diag");
   endtask
   initial begin
      for (int i = 0; i < NUM_DATA; i++) begin
         chan[i*WORD_W +: WORD_W] = 16'hA000 + 16'(i);
      end
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_warm();
      t_cfg();
      t_force();
      t_rate();
      t_fault();
      t_scal();
      t_diag();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      test_done();
   end
endmodule
